//--- dv/pem_host_model.sv
// Management host model that drives the register port of the monitor
`timescale 1ns/1ns
module pem_host_model (
   // Clock
   input  wire logic                      clk_in,
   // Register port toward the device
   output logic [pem_pkg::IDX_W-1:0]      addr_out,
   output logic [pem_pkg::IDX_W-1:0]      idx_out,
   output logic [pem_pkg::REG_W-1:0]      wdata_out,
   output logic                           wr_out,
   output logic                           rd_out,
   input  wire logic [pem_pkg::REG_W-1:0] rdata_in,
   input  wire logic                      rvalid_in
);
   import pem_pkg::*;
   // Target address, changed by the bench to probe a foreign PHY
   logic [4:0] target = 5'h01;
   initial begin
      addr_out  = 5'h01;
      idx_out   = 5'h00;
      wdata_out = 16'h0000;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end
   task automatic wr(input logic [4:0] i, input logic [15:0] d);
      @(negedge clk_in);
      addr_out  = target;
      idx_out   = i;
      wdata_out = d;
      wr_out    = 1'b1;
      @(negedge clk_in);
      wr_out    = 1'b0;
      // Stale data inverted so nothing relies on it
      wdata_out = ~d;
   endtask
   task automatic rd(input logic [4:0] i, output logic [15:0] d,
                     output logic ok);
      ok = 1'b0;
      d  = 16'h0000;
      @(negedge clk_in);
      addr_out = target;
      idx_out  = i;
      rd_out   = 1'b1;
      for (int k = 0; k < 3; k++) begin
         @(negedge clk_in);
         rd_out = 1'b0;
         if (!ok && rvalid_in === 1'b1) begin
            ok = 1'b1;
            d  = rdata_in;
         end
      end
   endtask
   // Aim the window at one register of a device, then switch to data
   task automatic sel(input logic [4:0] dev, input logic [15:0] a);
      wr(IDX_EXT_CTRL, {FN_ADDR, 9'h000, dev});
      wr(IDX_EXT_WIN, a);
      wr(IDX_EXT_CTRL, {FN_DATA, 9'h000, dev});
   endtask
   task automatic ext_wr(input logic [15:0] a, input logic [15:0] d);
      sel(EXT_DEV_QUALITY, a);
      wr(IDX_EXT_WIN, d);
   endtask
   task automatic ext_rd(input logic [4:0] dev, input logic [15:0] a,
                         output logic [15:0] d, output logic ok);
      sel(dev, a);
      rd(IDX_EXT_WIN, d, ok);
   endtask
endmodule

//--- dv/test_pem_monitor.sv
// Self-checking bench for the peak error monitor and loopback block
`timescale 1ns/1ns
`define CHK(a, e) begin \
   tests_run++; \
   if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h want %h", $time, a, e); \
   end \
end
module test_pem_monitor;
   import pem_pkg::*;
   // Short interval keeps the run brief
   localparam int unsigned N = 16;
   logic              clk_in   = 1'b0;
   logic              rst_n_in = 1'b0;
   logic [4:0]        pa, ri;
   logic [15:0]       wd, rdat, v;
   logic              wr, rd, rv, ok;
   logic              sv   = 1'b0;
   logic signed [6:0] err  = 7'sd0;
   logic              txe  = 1'b0;
   logic              lrdv = 1'b0;
   logic              lcol = 1'b0;
   logic [3:0]        txd  = 4'h0;
   logic [3:0]        lrxd = 4'h0;
   logic              rdv, col, ltxe, pwr;
   logic [3:0]        rxd, ltxd;
   int                n_mismatch = 0;
   int                tests_run  = 0;
   always #50 clk_in = ~clk_in;
   pem_host_model host (
      .clk_in(clk_in), .addr_out(pa), .idx_out(ri), .wdata_out(wd),
      .wr_out(wr), .rd_out(rd), .rdata_in(rdat), .rvalid_in(rv)
   );
   pem_monitor #(.INTERVAL_SYMBOLS(N)) uut (
      .clk_in(clk_in), .rst_n_in(rst_n_in),
      .mgmt_phy_addr_in(pa), .mgmt_reg_in(ri), .mgmt_wdata_in(wd),
      .mgmt_wr_in(wr), .mgmt_rd_in(rd),
      .mgmt_rdata_out(rdat), .mgmt_rvalid_out(rv),
      .sample_valid_in(sv), .slicer_err_in(err),
      .tx_en_in(txe), .txd_in(txd), .line_rx_dv_in(lrdv),
      .line_rxd_in(lrxd), .line_col_in(lcol),
      .rx_dv_out(rdv), .rxd_out(rxd), .col_out(col),
      .line_tx_en_out(ltxe), .line_txd_out(ltxd),
      .line_tx_power_out(pwr)
   );
   task automatic results();
      $display("mismatches %0d in %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Exactly N symbols of one error value
   task automatic feed(input logic signed [6:0] e);
      @(negedge clk_in);
      err = e;
      sv  = 1'b1;
      repeat (N) @(negedge clk_in);
      sv = 1'b0;
   endtask
   // Capture with a given configuration, then fetch the result word
   task automatic capt(input logic [15:0] c);
      host.ext_wr(EXT_ADDR_CFG, c | 16'h0004);
      repeat (3) @(negedge clk_in);
      host.ext_rd(EXT_DEV_QUALITY, EXT_ADDR_RESULT, v, ok);
   endtask
   initial begin
      #400000;
      n_mismatch++;
      results();
   end
   initial begin
      repeat (10) @(negedge clk_in);
      rst_n_in = 1'b1;
      @(negedge clk_in);
      `CHK(pwr, 1'b1)
      host.rd(IDX_BASE_CTRL, v, ok);
      `CHK(v, BC_RESET)
      host.rd(5'h05, v, ok);
      `CHK(({ok, v}), 17'h10000)
      host.target = 5'h02;
      host.rd(IDX_BASE_CTRL, v, ok);
      `CHK(ok, 1'b0)
      host.target = 5'h01;
      lcol = 1'b1;
      txe  = 1'b1;
      txd  = 4'hA;
      host.wr(IDX_BASE_CTRL, 16'h7100);
      @(negedge clk_in);
      `CHK(({rdv, rxd, col, ltxe, pwr}), 8'b1101_0000)
      host.wr(IDX_BASE_CTRL, 16'h7180);
      @(negedge clk_in);
      `CHK(col, 1'b1)
      host.wr(IDX_BASE_CTRL, 16'h3100);
      @(negedge clk_in);
      `CHK(({ltxe, ltxd, col, pwr}), 7'b1101_011)
      host.ext_wr(EXT_ADDR_CFG, 16'h0003);
      host.ext_rd(5'h1D, EXT_ADDR_CFG, v, ok);
      `CHK(v, 16'h0000)
      host.ext_rd(EXT_DEV_QUALITY, EXT_ADDR_CFG, v, ok);
      `CHK(v, 16'h0003)
      feed(7'sd8);
      capt(16'h0003);
      `CHK(v, 16'h0808)
      host.ext_rd(EXT_DEV_QUALITY, EXT_ADDR_CFG, v, ok);
      `CHK(v, 16'h0003)
      capt(16'h0103);
      `CHK(v[5:0], 6'h04)
      host.ext_wr(EXT_ADDR_CFG, 16'h0003);
      feed(7'sd32);
      // Capture a saturating peak without reading, so worst keeps it
      host.ext_wr(EXT_ADDR_CFG, 16'h0007);
      feed(7'sd8);
      capt(16'h0003);
      `CHK(v, 16'h3F08)
      feed(7'sd8);
      capt(16'h0003);
      `CHK(v, 16'h0808)
      // Disable first so the filter starts from zero
      host.ext_wr(EXT_ADDR_CFG, 16'h0000);
      host.ext_wr(EXT_ADDR_CFG, 16'h0013);
      feed(7'sd8);
      capt(16'h0013);
      `CHK(v, 16'h0707)
      host.ext_wr(EXT_ADDR_CFG, 16'h0000);
      feed(7'sd32);
      capt(16'h0000);
      `CHK(v[5:0], 6'h07)
      host.ext_wr(EXT_ADDR_CFG, 16'h0001);
      feed(-7'sd8);
      capt(16'h0001);
      `CHK(v[5:0], 6'h01)
      // Post-increment on read walks from configuration to result
      host.sel(EXT_DEV_QUALITY, EXT_ADDR_CFG);
      host.wr(IDX_EXT_CTRL, {FN_INC_RW, 9'h000, EXT_DEV_QUALITY});
      host.rd(IDX_EXT_WIN, v, ok);
      `CHK(v, 16'h0001)
      host.rd(IDX_EXT_WIN, v, ok);
      `CHK(v, 16'h0101)
      // Post-increment on write only; reads leave the address alone
      host.sel(EXT_DEV_QUALITY, EXT_ADDR_CFG);
      host.wr(IDX_EXT_CTRL, {FN_INC_W, 9'h000, EXT_DEV_QUALITY});
      host.wr(IDX_EXT_WIN, 16'h0013);
      host.rd(IDX_EXT_WIN, v, ok);
      `CHK(v, 16'h0101)
      host.wr(IDX_EXT_CTRL, {FN_ADDR, 9'h000, EXT_DEV_QUALITY});
      host.rd(IDX_EXT_WIN, v, ok);
      `CHK(v, EXT_ADDR_RESULT)
      // Soft reset wins over a loopback request and clears the config
      host.wr(IDX_BASE_CTRL, 16'hC000);
      host.rd(IDX_BASE_CTRL, v, ok);
      `CHK(v, BC_RESET)
      host.ext_rd(EXT_DEV_QUALITY, EXT_ADDR_CFG, v, ok);
      `CHK(v, 16'h0000)
      results();
   end
endmodule

//--- hdl/pem_monitor.sv
// Peak error monitor, extended register access and near-end loopback
// Notes on behaviour
// - Monitor runs only while enable bit set
// - Filter adds weighted error difference each sample
// - Weight is divide by two to gain
// - Store interval maximum every 65536 symbols
// - Result is peak over two to scale+3
// - Result saturates at 63
// - Capture bit self-clears and latches result
// - Result register also holds worst case
// - Quality registers live under device 30
// - Loopback routes transmit data to receive
// - Loopback keeps collision quiet unless self-test
// - Loopback powers transmitters down
// - Answer only own management address
// - Indirect access through indexes 13 and 14
// - Loopback is control bit 14, reset zero
// - Collision self-test bit 7 asserts collision while tx_en_in is high
`timescale 1ns/1ns
module pem_monitor #(
   parameter logic [4:0]  PHY_ADDR         = 5'h01,
   parameter int unsigned INTERVAL_SYMBOLS = pem_pkg::INTERVAL_SYMBOLS
) (
   // Clock and reset
   input  wire logic                              clk_in,
   input  wire logic                              rst_n_in,
   // Management register port
   input  wire logic [pem_pkg::IDX_W-1:0]         mgmt_phy_addr_in,
   input  wire logic [pem_pkg::IDX_W-1:0]         mgmt_reg_in,
   input  wire logic [pem_pkg::REG_W-1:0]         mgmt_wdata_in,
   input  wire logic                              mgmt_wr_in,
   input  wire logic                              mgmt_rd_in,
   output logic      [pem_pkg::REG_W-1:0]         mgmt_rdata_out,
   output logic                                   mgmt_rvalid_out,
   // Receive slicer error
   input  wire logic                              sample_valid_in,
   input  wire logic signed [pem_pkg::ERR_W-1:0]  slicer_err_in,
   // MII side and line side
   input  wire logic                              tx_en_in,
   input  wire logic [3:0]                        txd_in,
   input  wire logic                              line_rx_dv_in,
   input  wire logic [3:0]                        line_rxd_in,
   input  wire logic                              line_col_in,
   output logic                                   rx_dv_out,
   output logic      [3:0]                        rxd_out,
   output logic                                   col_out,
   output logic                                   line_tx_en_out,
   output logic      [3:0]                        line_txd_out,
   output logic                                   line_tx_power_out
);
   import pem_pkg::*;

   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INTERVAL_SYMBOLS - 1);

   logic [REG_W-1:0] base_ctrl, next_base_ctrl, ext_ctrl, next_ext_ctrl;
   logic [REG_W-1:0] ext_addr, next_ext_addr, cfg, next_cfg;
   logic [REG_W-1:0] next_rdata, ext_rd_val;
   logic             capture_pulse, next_capture_pulse, next_rvalid;
   logic             sel, wr, rd, data_fn, dev_ok, win_wr, win_rd;
   logic             result_read;
   logic [1:0]       fn;

   logic [ACC_W-1:0]   acc, next_acc;
   logic [CNT_W-1:0]   cnt, next_cnt;
   logic [SQ_W-1:0]    int_max, next_int_max, stored, next_stored;
   logic [SQ_W-1:0]    sq_val, filt_new, peak_new;
   logic [RES_W-1:0]   result_cur, next_result_cur, worst, next_worst;
   logic [RES_W-1:0]   scaled_now, scaled_new;
   logic               worst_seed, next_worst_seed, store_evt, en, loop_on;
   logic [5:0]         mag;
   logic signed [ACC_W:0] diff, step;
   logic [FLD_W-1:0]   gain, scale;

   function automatic logic [RES_W-1:0] sat_scale(
      input logic [SQ_W-1:0]  val,
      input logic [FLD_W-1:0] sh
   );
      logic [SQ_W-1:0] q;
      q = val >> (32'(sh) + SCALE_BIAS);
      sat_scale = (q > SQ_W'(RES_MAX)) ? RES_MAX : q[RES_W-1:0];
   endfunction

   // Register access decode
   assign sel     = (mgmt_phy_addr_in == PHY_ADDR);
   assign wr      = mgmt_wr_in & sel;
   assign rd      = mgmt_rd_in & sel;
   assign fn      = ext_ctrl[EC_FN_LSB+:2];
   assign data_fn = (fn != FN_ADDR);
   assign dev_ok  = (ext_ctrl[IDX_W-1:0] == EXT_DEV_QUALITY);
   assign win_wr  = wr & (mgmt_reg_in == IDX_EXT_WIN) & data_fn & dev_ok;
   assign win_rd  = rd & (mgmt_reg_in == IDX_EXT_WIN) & data_fn & dev_ok;
   assign result_read = win_rd & (ext_addr == EXT_ADDR_RESULT);

   always_comb begin
      ext_rd_val = '0;
      if (ext_addr == EXT_ADDR_CFG) begin
         ext_rd_val = cfg;
      end else if (ext_addr == EXT_ADDR_RESULT) begin
         ext_rd_val[RES_CUR_LSB+:RES_W]   = result_cur;
         ext_rd_val[RES_WORST_LSB+:RES_W] = worst;
      end
   end

   always_comb begin
      next_base_ctrl     = base_ctrl;
      next_ext_ctrl      = ext_ctrl;
      next_ext_addr      = ext_addr;
      next_cfg           = cfg;
      next_capture_pulse = 1'b0;
      next_rvalid        = rd;
      next_rdata         = '0;
      if (wr) begin
         case (mgmt_reg_in)
            IDX_BASE_CTRL: begin
               // Soft reset loads BC_RESET and CFG_RESET; the reset bit itself reads back zero
               if (mgmt_wdata_in[BC_SOFT_RST]) begin
                  next_base_ctrl = BC_RESET;
                  next_cfg       = CFG_RESET;
               end else begin
                  next_base_ctrl = mgmt_wdata_in & BC_WMASK;
               end
            end
            IDX_EXT_CTRL: next_ext_ctrl = mgmt_wdata_in & EC_WMASK;
            IDX_EXT_WIN: begin
               if (!data_fn) begin
                  next_ext_addr = mgmt_wdata_in;
               end else if (win_wr && ext_addr == EXT_ADDR_CFG) begin
                  next_cfg           = mgmt_wdata_in & CFG_WMASK;
                  next_capture_pulse = mgmt_wdata_in[CFG_CAPT];
               end
            end
            default: ;
         endcase
      end
      if ((win_rd && fn == FN_INC_RW) ||
          (win_wr && (fn == FN_INC_RW || fn == FN_INC_W))) begin
         next_ext_addr = ext_addr + 16'h0001;
      end
      if (rd) begin
         case (mgmt_reg_in)
            IDX_BASE_CTRL: next_rdata = base_ctrl;
            IDX_EXT_CTRL:  next_rdata = ext_ctrl;
            IDX_EXT_WIN:   next_rdata = !data_fn ? ext_addr :
                                        dev_ok ? ext_rd_val : '0;
            default:       next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         base_ctrl       <= BC_RESET;
         ext_ctrl        <= '0;
         ext_addr        <= '0;
         cfg             <= CFG_RESET;
         capture_pulse   <= 1'b0;
         mgmt_rdata_out  <= '0;
         mgmt_rvalid_out <= 1'b0;
      end else begin
         base_ctrl       <= next_base_ctrl;
         ext_ctrl        <= next_ext_ctrl;
         ext_addr        <= next_ext_addr;
         cfg             <= next_cfg;
         capture_pulse   <= next_capture_pulse;
         mgmt_rdata_out  <= next_rdata;
         mgmt_rvalid_out <= next_rvalid;
      end
   end

   // Peak error datapath
   assign en    = cfg[CFG_EN];
   assign gain  = cfg[CFG_GAIN_LSB+:FLD_W];
   assign scale = cfg[CFG_SCALE_LSB+:FLD_W];
   assign mag   = slicer_err_in[ERR_W-1] ? 6'(-slicer_err_in)
                                         : 6'(slicer_err_in);
   // Absolute mode kept for bring-up; squared mode is the intended use
   // Widen before squaring so the top bit of 32 squared is kept
   assign sq_val = cfg[CFG_SQU] ? SQ_W'(mag) * SQ_W'(mag) : SQ_W'(mag);
   assign diff   = $signed({1'b0, sq_val, FRAC_W'(0)})
                 - $signed({1'b0, acc});
   assign step   = diff >>> gain;
   assign filt_new = next_acc[ACC_W-1:FRAC_W];
   assign peak_new = (filt_new > int_max) ? filt_new : int_max;
   assign store_evt  = en & sample_valid_in & (cnt == CNT_LAST);
   assign scaled_now = sat_scale(stored, scale);
   assign scaled_new = sat_scale(peak_new, scale);

   always_comb begin
      next_acc        = acc;
      next_cnt        = cnt;
      next_int_max    = int_max;
      next_stored     = stored;
      next_result_cur = result_cur;
      next_worst      = worst;
      next_worst_seed = worst_seed;
      if (!en) begin
         // Disabled monitor restarts cleanly on the next enable
         next_acc     = '0;
         next_cnt     = '0;
         next_int_max = '0;
      end else if (sample_valid_in) begin
         next_acc = ACC_W'($signed({1'b0, acc}) + step);
         if (store_evt) begin
            next_stored  = peak_new;
            next_int_max = '0;
            next_cnt     = '0;
         end else begin
            next_int_max = peak_new;
            next_cnt     = cnt + 1'b1;
         end
      end
      if (capture_pulse) begin
         next_result_cur = scaled_now;
      end
      // A read in the same cycle makes this store the new seed
      if (store_evt) begin
         next_worst_seed = 1'b0;
         if (worst_seed || result_read || scaled_new > worst) begin
            next_worst = scaled_new;
         end
      end else if (result_read) begin
         next_worst_seed = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc        <= '0;
         cnt        <= '0;
         int_max    <= '0;
         stored     <= '0;
         result_cur <= '0;
         worst      <= '0;
         worst_seed <= 1'b1;
      end else begin
         acc        <= next_acc;
         cnt        <= next_cnt;
         int_max    <= next_int_max;
         stored     <= next_stored;
         result_cur <= next_result_cur;
         worst      <= next_worst;
         worst_seed <= next_worst_seed;
      end
   end

   // Near-end loopback path
   assign loop_on = base_ctrl[BC_LOOP];
   logic       next_rx_dv, next_col, next_tx_en, next_power;
   logic [3:0] next_rxd, next_txd;

   always_comb begin
      next_rx_dv = loop_on ? tx_en_in : line_rx_dv_in;
      next_rxd   = loop_on ? txd_in : line_rxd_in;
      next_col   = loop_on ? (base_ctrl[BC_COL_TEST] & tx_en_in)
                           : (line_col_in |
                              (base_ctrl[BC_COL_TEST] & tx_en_in));
      next_tx_en = ~loop_on & tx_en_in;
      next_txd   = loop_on ? 4'h0 : txd_in;
      next_power = ~loop_on & ~base_ctrl[BC_PWR_DWN];
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_dv_out         <= 1'b0;
         rxd_out           <= 4'h0;
         col_out           <= 1'b0;
         line_tx_en_out    <= 1'b0;
         line_txd_out      <= 4'h0;
         line_tx_power_out <= 1'b0;
      end else begin
         rx_dv_out         <= next_rx_dv;
         rxd_out           <= next_rxd;
         col_out           <= next_col;
         line_tx_en_out    <= next_tx_en;
         line_txd_out      <= next_txd;
         line_tx_power_out <= next_power;
      end
   end

   // Checks
   // Reference quotient; a wide shift amount avoids wrap at scale 13+
   logic [SQ_W-1:0] chk_quot;
   assign chk_quot = stored >> (32'(scale) + SCALE_BIAS);
   sequence s_capt_req;
      win_wr && ext_addr == EXT_ADDR_CFG && mgmt_wdata_in[CFG_CAPT];
   endsequence
   a_capt_result: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s_capt_req |=> capture_pulse ##1 (!capture_pulse &&
         result_cur == $past(scaled_now)))
      else $error("capture did not latch result");
   a_scale_sat: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      capture_pulse && chk_quot > SQ_W'(RES_MAX)
      |=> result_cur == RES_MAX)
      else $error("result not saturated");
   a_scale_div: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      capture_pulse && chk_quot <= SQ_W'(RES_MAX)
      |=> SQ_W'(result_cur) == $past(chk_quot))
      else $error("result scaling wrong");
   a_idle_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !en |=> acc == '0 && cnt == '0)
      else $error("monitor active while disabled");
   a_filter_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      en && sample_valid_in && sq_val > acc[ACC_W-1:FRAC_W] && gain == 4'h0
      |=> acc[ACC_W-1:FRAC_W] == $past(sq_val))
      else $error("unity gain filter step wrong");
   a_peak_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      store_evt |=> stored >= $past(int_max) && cnt == '0)
      else $error("interval peak not stored");
   a_worst_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      store_evt && !worst_seed && !result_read
      |=> worst >= $past(worst))
      else $error("worst case dropped");
   a_read_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      result_read && !store_evt |=> worst_seed)
      else $error("worst case not restarted");
   a_own_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mgmt_phy_addr_in != PHY_ADDR |=> !mgmt_rvalid_out)
      else $error("answered foreign address");
   a_loop_tx_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      loop_on |=> !line_tx_en_out && !line_tx_power_out)
      else $error("transmitter active in loopback");
   a_loop_col: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      loop_on && !base_ctrl[BC_COL_TEST] |=> !col_out)
      else $error("collision in loopback");
   a_loop_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      loop_on |=> rx_dv_out == $past(tx_en_in)
         && rxd_out == $past(txd_in))
      else $error("loopback data not returned");
endmodule

//--- hdl/pem_pkg.sv
// Constants for the peak error monitor and loopback control block
package pem_pkg;
   localparam int unsigned REG_W = 16;
   localparam int unsigned IDX_W = 5;
   // Management register indexes
   localparam logic [4:0] IDX_BASE_CTRL = 5'h00;
   localparam logic [4:0] IDX_EXT_CTRL  = 5'h0D;
   localparam logic [4:0] IDX_EXT_WIN   = 5'h0E;
   // Extended space device and register addresses
   localparam logic [4:0]  EXT_DEV_QUALITY = 5'h1E;
   localparam logic [15:0] EXT_ADDR_CFG    = 16'h00D0;
   localparam logic [15:0] EXT_ADDR_RESULT = 16'h00D1;
   // Basic control bits
   localparam int unsigned BC_SOFT_RST = 15;
   localparam int unsigned BC_LOOP     = 14;
   localparam int unsigned BC_PWR_DWN  = 11;
   localparam int unsigned BC_COL_TEST = 7;
   localparam logic [15:0] BC_RESET    = 16'h3100;
   localparam logic [15:0] BC_WMASK    = 16'h7980;
   // Extended access control fields
   localparam int unsigned EC_FN_LSB = 14;
   localparam logic [15:0] EC_WMASK  = 16'hC01F;
   localparam logic [1:0]  FN_ADDR   = 2'h0;
   localparam logic [1:0]  FN_DATA   = 2'h1;
   localparam logic [1:0]  FN_INC_RW = 2'h2;
   localparam logic [1:0]  FN_INC_W  = 2'h3;
   // Quality configuration fields
   localparam int unsigned CFG_EN        = 0;
   localparam int unsigned CFG_SQU       = 1;
   localparam int unsigned CFG_CAPT      = 2;
   localparam int unsigned CFG_GAIN_LSB  = 4;
   localparam int unsigned CFG_SCALE_LSB = 8;
   localparam int unsigned FLD_W         = 4;
   localparam logic [15:0] CFG_RESET     = 16'h0000;
   localparam logic [15:0] CFG_WMASK     = 16'h0FF3;
   // Result fields
   localparam int unsigned RES_CUR_LSB   = 0;
   localparam int unsigned RES_WORST_LSB = 8;
   localparam int unsigned RES_W         = 6;
   localparam logic [5:0]  RES_MAX       = 6'h3F;
   localparam int unsigned SCALE_BIAS    = 3;
   // Datapath widths
   localparam int unsigned ERR_W  = 7;
   localparam int unsigned SQ_W   = 11;
   localparam int unsigned FRAC_W = 16;
   localparam int unsigned ACC_W  = SQ_W + FRAC_W;
   // Peak interval in received symbols
   localparam int unsigned INTERVAL_SYMBOLS = 65536;
   localparam int unsigned CNT_W            = 17;
endpackage
